// file: bpio_top.sv
// three buffered 16-bit parallel i/o ports on a bit-addressed bus
//
// Summary of operation
// - input mode reads return connector pin levels
// - output mode reads still sample pins
// - 32 flag bits per port, 96 total
// - flags written and read per bit
// - port led lit while reset-arm active
// - flag 0 is reset-arm, reads led state
// - written output value held until changed
// - written block stays output until reset
// - soft reset before input; flag 15 holds written bit
// - switches enable port and inhibit drivers
// - hardware reset makes all blocks inputs
// - one bit write enables whole block
// - arm bit 0, then bit 15 resets
// - window: flags at 0/32, pins 16/48
`timescale 1ns/1ps
`include "bpio_defs.svh"
module bpio_top #(
  parameter int NPORTS = 3,
  parameter int PORT_W = 16,
  parameter int FLAG_W = 32
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // bit-addressed i/o bus
  input wire bpio_pkg::bpio_bus_req_s bus_i,
  output logic bus_rdata_o,
  output logic bus_rvalid_o,
  // per-port switches and strap
  input wire logic [NPORTS*(`BPIO_ADDR_W-`BPIO_WIN_BITS)-1:0] port_base_sw_i,
  input wire logic [NPORTS-1:0] port_enable_switch_i,
  input wire logic [NPORTS-1:0] output_inhibit_switch_i,
  input wire logic flag_storage_strap_i,
  // connector pins
  input wire logic [NPORTS*PORT_W-1:0] pin_i,
  output logic [NPORTS*PORT_W-1:0] pin_o,
  output logic [NPORTS*PORT_W-1:0] pin_oe_o,
  // reset-arm leds
  output logic [NPORTS-1:0] led_o
);
  localparam int BASE_W = `BPIO_ADDR_W - `BPIO_WIN_BITS;
  localparam int NBLK = NPORTS * PORT_W / `BPIO_BLK_W;
  localparam int BLK_PER_PORT = PORT_W / `BPIO_BLK_W;

  logic [FLAG_W-1:0] flags_q [NPORTS];
  logic [FLAG_W-1:0] flags_d [NPORTS];
  logic rdata_q;
  logic rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [NPORTS-1:0] soft_rst;
  bpio_pkg::bpio_blk_req_s blk_req [NBLK];
  logic [`BPIO_BLK_W-1:0] blk_data [NBLK];
  logic [NBLK-1:0] blk_mode;

  function automatic logic port_hit(
    input logic [`BPIO_ADDR_W-1:0] addr,
    input logic [BASE_W-1:0] base,
    input logic en
  );
    port_hit = en && (addr[`BPIO_ADDR_W-1:`BPIO_WIN_BITS] == base);
  endfunction

  function automatic bpio_pkg::bpio_grp_e grp_of(input logic [`BPIO_ADDR_W-1:0] addr);
    grp_of = bpio_pkg::bpio_grp_e'(addr[`BPIO_GRP_MSB:`BPIO_GRP_LSB]);
  endfunction

  always_comb
  begin
    logic [3:0] idx;
    logic [BASE_W-1:0] base;
    logic hit;
    int blk;
    idx = bus_i.addr[`BPIO_IDX_MSB:0];
    base = '0;
    hit = 1'b0;
    blk = 0;
    rdata_d = 1'b0;
    rvalid_d = 1'b0;
    soft_rst = '0;
    for (int p = 0; p < NPORTS; p++)
    begin
      flags_d[p] = flags_q[p];
    end
    for (int b = 0; b < NBLK; b++)
    begin
      blk_req[b].wr = 1'b0;
      blk_req[b].sel = bus_i.addr[2:0];
      blk_req[b].wdata = bus_i.wdata;
    end
    for (int p = 0; p < NPORTS; p++)
    begin
      base = port_base_sw_i[p*BASE_W +: BASE_W];
      hit = port_hit(bus_i.addr, base, port_enable_switch_i[p]);
      blk = p * BLK_PER_PORT + int'(bus_i.addr[`BPIO_BLK_SEL_BIT]);
      if (hit && bus_i.wr)
      begin
        case (grp_of(bus_i.addr))
          bpio_pkg::BPIO_GRP_FLAGS_LO:
          begin
            if (idx == `BPIO_ARM_BIT || idx == `BPIO_RESET_BIT || flag_storage_strap_i)
            begin
              flags_d[p][idx] = bus_i.wdata;
            end
            if (idx == `BPIO_RESET_BIT && flags_q[p][`BPIO_ARM_BIT])
            begin
              soft_rst[p] = 1'b1;
            end
          end
          bpio_pkg::BPIO_GRP_FLAGS_HI:
          begin
            if (flag_storage_strap_i)
            begin
              flags_d[p][`BPIO_FLAG_HI_BASE + int'(idx)] = bus_i.wdata;
            end
          end
          bpio_pkg::BPIO_GRP_PINS, bpio_pkg::BPIO_GRP_PINS_ALIAS:
          begin
            blk_req[blk].wr = 1'b1;
          end
          default:
          begin
            blk_req[blk].wr = 1'b0;
          end
        endcase
      end
      if (hit && bus_i.rd)
      begin
        rvalid_d = 1'b1;
        case (grp_of(bus_i.addr))
          bpio_pkg::BPIO_GRP_FLAGS_LO:
          begin
            if (idx == `BPIO_ARM_BIT || idx == `BPIO_RESET_BIT || flag_storage_strap_i)
            begin
              rdata_d = flags_q[p][idx];
            end
          end
          bpio_pkg::BPIO_GRP_FLAGS_HI:
          begin
            if (flag_storage_strap_i)
            begin
              rdata_d = flags_q[p][`BPIO_FLAG_HI_BASE + int'(idx)];
            end
          end
          bpio_pkg::BPIO_GRP_PINS, bpio_pkg::BPIO_GRP_PINS_ALIAS:
          begin
            // always the pin level, so echo checks the drivers
            rdata_d = pin_i[p*PORT_W + int'(idx)];
          end
          default:
          begin
            rdata_d = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        flags_q[p] <= `BPIO_FLAGS_RST;
      end
      rdata_q <= 1'b0;
      rvalid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        flags_q[p] <= flags_d[p];
      end
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  for (genvar b = 0; b < NBLK; b++)
  begin : g_blk
    bpio_io_block #(
      .BLK_W(`BPIO_BLK_W)
    ) u_blk (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .req_i(blk_req[b]),
      .soft_rst_i(soft_rst[b / BLK_PER_PORT]),
      .data_o(blk_data[b]),
      .out_mode_o(blk_mode[b])
    );
    assign pin_o[b*`BPIO_BLK_W +: `BPIO_BLK_W] = blk_data[b];
    assign pin_oe_o[b*`BPIO_BLK_W +: `BPIO_BLK_W] =
      {`BPIO_BLK_W{blk_mode[b] & ~output_inhibit_switch_i[b / BLK_PER_PORT]}};
  end

  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      led_o[p] = flags_q[p][`BPIO_ARM_BIT];
    end
  end

  assign bus_rdata_o = rdata_q;
  assign bus_rvalid_o = rvalid_q;
endmodule

// file: bpio_defs.svh
// constants for the buffered parallel i/o ports
`ifndef BPIO_DEFS_SVH
`define BPIO_DEFS_SVH
`define BPIO_ADDR_W 12
`define BPIO_WIN_BITS 6
`define BPIO_OFS_FLAGS_LO 8'h00
`define BPIO_OFS_PINS 8'h20
`define BPIO_OFS_FLAGS_HI 8'h40
`define BPIO_OFS_PINS_ALIAS 8'h60
`define BPIO_GRP_MSB 5
`define BPIO_GRP_LSB 4
`define BPIO_IDX_MSB 3
`define BPIO_BLK_SEL_BIT 3
`define BPIO_ARM_BIT 4'h0
`define BPIO_RESET_BIT 4'hF
`define BPIO_FLAG_HI_BASE 16
`define BPIO_BLK_W 8
`define BPIO_FLAGS_RST 32'h0000_0000
`endif

// file: bpio_pkg.sv
// types shared by the parallel i/o port files
package bpio_pkg;
  // window group, from the two top bits of the in-window bit address
  typedef enum logic [1:0] {
    BPIO_GRP_FLAGS_LO = 2'b00,
    BPIO_GRP_PINS = 2'b01,
    BPIO_GRP_FLAGS_HI = 2'b10,
    BPIO_GRP_PINS_ALIAS = 2'b11
  } bpio_grp_e;

  // one bit-addressed bus cycle from the host
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic wdata;
    logic rd;
  } bpio_bus_req_s;

  // per-block write request
  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic wdata;
  } bpio_blk_req_s;
endpackage

// file: bpio_io_block.sv
// one 8-bit output block: data latches and output-mode flag
`timescale 1ns/1ps
`include "bpio_defs.svh"
module bpio_io_block #(
  parameter int BLK_W = `BPIO_BLK_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control
  input wire bpio_pkg::bpio_blk_req_s req_i,
  input wire logic soft_rst_i,
  // state
  output logic [BLK_W-1:0] data_o,
  output logic out_mode_o
);
  logic [BLK_W-1:0] data_q;
  logic [BLK_W-1:0] data_d;
  logic mode_q;
  logic mode_d;

  always_comb
  begin
    data_d = data_q;
    mode_d = mode_q;
    if (soft_rst_i)
    begin
      data_d = '0;
      mode_d = 1'b0;
    end
    else if (req_i.wr)
    begin
      data_d[req_i.sel] = req_i.wdata;
      mode_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_q <= '0;
      mode_q <= 1'b0;
    end
    else if (ce_i)
    begin
      data_q <= data_d;
      mode_q <= mode_d;
    end
  end

  assign data_o = data_q;
  assign out_mode_o = mode_q;
endmodule

// file: bpio_assertions.sv
// concurrent checks on the parallel i/o port top
`timescale 1ns/1ps
module bpio_assertions #(
  parameter int NPORTS = 3,
  parameter int PORT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // bus
  input wire bpio_pkg::bpio_bus_req_s bus_i,
  input wire logic bus_rdata_o,
  input wire logic bus_rvalid_o,
  // switches
  input wire logic [NPORTS*6-1:0] port_base_sw_i,
  input wire logic [NPORTS-1:0] port_enable_switch_i,
  input wire logic [NPORTS-1:0] output_inhibit_switch_i,
  // pins and leds
  input wire logic [NPORTS*PORT_W-1:0] pin_i,
  input wire logic [NPORTS*PORT_W-1:0] pin_o,
  input wire logic [NPORTS*PORT_W-1:0] pin_oe_o,
  input wire logic [NPORTS-1:0] led_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // port 0 only: other ports share the same logic
  wire base0 = bus_i.addr[11:6] == port_base_sw_i[5:0];
  wire hit0 = ce_i && port_enable_switch_i[0] && base0;
  wire wr0 = hit0 && bus_i.wr;
  wire [5:0] ofs = bus_i.addr[5:0];
  wire pbit = pin_i[bus_i.addr[3:0]];
  rd_pin_a: assert property (hit0 && bus_i.rd && ofs[4]
    |=> bus_rvalid_o && bus_rdata_o == $past(pbit)) else $error("pin read wrong");
  miss_a: assert property (ce_i && bus_i.rd && base0 && !hit0
    |=> !bus_rvalid_o) else $error("answer from disabled port");
  oe_blk_a: assert property (wr0 && ofs[4] && !ofs[3]
    |=> output_inhibit_switch_i[0] || pin_oe_o[7:0] == 8'hFF) else $error("block not driven");
  mode_hold_a: assert property (pin_oe_o[0] && !led_o[0]
    |=> pin_oe_o[0] || output_inhibit_switch_i[0]) else $error("output mode lost");
  inhibit_a: assert property (output_inhibit_switch_i[0]
    |-> pin_oe_o[PORT_W-1:0] == '0) else $error("inhibited port drives");
  latch_a: assert property (!(wr0 && ofs[4:0] == 5'h10) && !led_o[0]
    |=> $stable(pin_o[0])) else $error("latch changed");
  led_a: assert property (wr0 && ofs == 6'h00
    |=> led_o[0] == $past(bus_i.wdata)) else $error("led wrong");
  srst_a: assert property (wr0 && ofs == 6'h0F && led_o[0]
    |=> pin_oe_o[PORT_W-1:0] == '0 && pin_o[PORT_W-1:0] == '0) else $error("soft reset failed");
endmodule
bind bpio_top bpio_assertions #(.NPORTS(NPORTS), .PORT_W(PORT_W)) u_bpio_assertions (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
  .bus_rvalid_o(bus_rvalid_o), .port_base_sw_i(port_base_sw_i),
  .port_enable_switch_i(port_enable_switch_i), .output_inhibit_switch_i(output_inhibit_switch_i),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .led_o(led_o));

// file: bpio_pin_model.sv
// connector model: external device drives where the board does not
`timescale 1ns/1ps
module bpio_pin_model (
  // board side
  input wire logic [47:0] drv_i,
  input wire logic [47:0] oe_i,
  // external device
  input wire logic [47:0] ext_i,
  output logic [47:0] lvl_o
);
  // driven pins show the board latch, others the external level
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// file: bpio_tb.sv
// self-checking bench for the parallel i/o ports
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  bpio_pkg::bpio_bus_req_s bus_q = '0;
  logic [2:0] en_q = 3'h7;
  logic [2:0] inh_q = 3'h0;
  logic ce_q = 1'b1;
  logic strap_q = 1'b1;
  logic [47:0] ext_q = 48'hA5C3_1234_5678;
  logic [47:0] pin_w, pin_o, pin_oe;
  logic [2:0] led;
  logic rdata, rvalid;
  int n_errors = 0;
  int total_checks = 0;
  initial forever #25 clk_i = ~clk_i;
  bpio_top u_bpio_top (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_q), .bus_i(bus_q),
    .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .port_base_sw_i({6'h14, 6'h10, 6'h0C}),
    .port_enable_switch_i(en_q), .output_inhibit_switch_i(inh_q),
    .flag_storage_strap_i(strap_q), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .led_o(led));
  bpio_pin_model u_bpio_pin_model (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext_q), .lvl_o(pin_w));
  task chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic d);
    @(negedge clk_i);
    bus_q = '{addr: a, wr: 1'b1, wdata: d, rd: 1'b0};
    @(negedge clk_i);
    bus_q.wr = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic v, input logic d);
    @(negedge clk_i);
    bus_q = '{addr: a, wr: 1'b0, wdata: 1'b0, rd: 1'b1};
    @(negedge clk_i);
    bus_q.rd = 1'b0;
    chk({46'h0, rvalid, rdata}, {46'h0, v, d});
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bound well above the 55 or so cycles the sequence needs
  initial
  begin
    #200000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    rd(12'h301, 1, 0);
    wr(12'h301, 1);
    wr(12'h32F, 1);
    rd(12'h301, 1, 1);
    rd(12'h32F, 1, 1);
    rd(12'h42F, 1, 0);
    // strap off: plain flags neither stored nor shown
    strap_q = 1'b0;
    wr(12'h305, 1);
    rd(12'h301, 1, 0);
    strap_q = 1'b1;
    rd(12'h305, 1, 0);
    rd(12'h313, 1, ext_q[3]);
    rd(12'h334, 1, ext_q[4]);
    wr(12'h313, 1);
    chk(pin_oe, 48'h0000_0000_00FF);
    chk(pin_o, 48'h0000_0000_0008);
    rd(12'h334, 1, 0);
    // frozen clock enable: the write must not land
    ce_q = 1'b0;
    wr(12'h310, 1);
    ce_q = 1'b1;
    chk(pin_o, 48'h0000_0000_0008);
    inh_q[0] = 1'b1;
    #1 chk(pin_oe, 48'h0);
    rd(12'h314, 1, ext_q[4]);
    inh_q[0] = 1'b0;
    en_q[0] = 1'b0;
    rd(12'h313, 0, 0);
    en_q[0] = 1'b1;
    // unarmed bit 15 write only stores the flag
    wr(12'h30F, 1);
    rd(12'h30F, 1, 1);
    chk(pin_oe, 48'h0000_0000_00FF);
    wr(12'h300, 1);
    chk({45'h0, led}, 48'h1);
    rd(12'h300, 1, 1);
    // host side: arm first, then strike bit 15 before reading inputs
    wr(12'h30F, 0);
    chk(pin_oe, 48'h0);
    rd(12'h30F, 1, 0);
    rd(12'h314, 1, ext_q[4]);
    wr(12'h300, 0);
    chk({45'h0, led}, 48'h0);
    wr(12'h418, 1);
    chk(pin_oe, 48'h0000_FF00_0000);
    nrst_i = 1'b0;
    #1 chk(pin_oe, 48'h0);
    @(negedge clk_i) nrst_i = 1'b1;
    rd(12'h32F, 1, 0);
    print_verdict;
  end
endmodule
